// ### hdl/ccs_regs.sv
// Top module of the charger control and status register bank.
`timescale 1ns/1ns
module ccs_regs (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  // Register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // Analog events and measurements
  input  wire logic        OUT_UVLO,
  input  wire logic        INPUT_PRESENT,
  input  wire logic [11:0] BAT_MINUS_OUT_MV,
  input  wire logic        BAT_MINUS_OUT_POS,
  input  wire logic        LOAD_OVER_LIMIT,
  // Live status inputs
  input  wire logic        USB_SELECTED,
  input  wire logic        DYNAMIC_POWER_PATH_MANAGEMENT_ACTIVE,
  input  wire logic        THERMAL_ACTIVE,
  input  wire logic        WALL_INPUT_PRESENT,
  input  wire logic        USB_INPUT_PRESENT,
  input  wire logic [1:0]  CHARGE_STATE,
  input  wire logic        AC_OVERVOLTAGE,
  input  wire logic        USB_OVERVOLTAGE,
  input  wire logic        PM_REG_OK,
  // Charger controls
  output logic             CHARGE_VOLTAGE_SELECT,
  output logic             CHARGE_VOLTAGE_GUARD_BIT,
  output logic             SUSPEND_CHARGE_CONTROL,
  output logic             TIMERS_HOLD,
  output logic [2:0]       CURRENT_CFG,
  output logic             INPUT_LIMIT_MAX,
  output logic             SYSTEM_FROM_INPUT,
  output logic             SUPPLEMENT_FLAG,
  output logic             STATUS_IRQ_EVENT
);
  // ----------------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;
  // Two-stage release keeps deassertion synchronous to the clock.
  // Requests are honoured from the third edge after the external release.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Status composition
  // ----------------------------------------------------------------------------
  ccs_stat_if st ();
  logic supp_q;
  logic supp_d;

  assign st.supp_flag = supp_q;
  assign st.usb_sel   = USB_SELECTED;
  assign st.dynamic_power_path_management_on   = DYNAMIC_POWER_PATH_MANAGEMENT_ACTIVE;
  assign st.therm_on  = THERMAL_ACTIVE;
  assign st.ac_pg     = WALL_INPUT_PRESENT;
  assign st.usb_pg    = USB_INPUT_PRESENT;
  assign st.chg_state = CHARGE_STATE;
  assign st.ac_ov     = AC_OVERVOLTAGE;
  assign st.usb_ov    = USB_OVERVOLTAGE;
  assign st.pm_ok     = PM_REG_OK;

  ccs_stat_comp u_comp (
    .st (st.comp)
  );

  // ----------------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------------
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] gpio_q, gpio_d;
  logic       latch_q, latch_d;
  logic       uvlo_q, uvlo_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] prev_stat_q, prev_stat_d;
  logic       irq_q, irq_d;
  logic       en_eff;

  // Enable latch, lockout tracking, supplement hysteresis and register writes.
  always_comb begin
    cfg_d   = cfg_q;
    gpio_d  = gpio_q;
    latch_d = latch_q;
    uvlo_d  = OUT_UVLO;
    supp_d  = supp_q;
    if (REG_WR && REG_ADDR == ccs_pkg::ADDR_CHG_CFG) begin
      cfg_d = REG_WDATA & ccs_pkg::CFG_WR_MASK;
    end
    if (REG_WR && REG_ADDR == ccs_pkg::ADDR_PIN3_GUARD) begin
      gpio_d = REG_WDATA;
    end
    // Lockout entry: capture first, then default the register; lockout wins over a write.
    if (OUT_UVLO && !uvlo_q) begin
      latch_d = cfg_q[ccs_pkg::BIT_ENABLE];
      cfg_d   = ccs_pkg::RST_CHG_CFG;
    end
    // Removing input power restores the latch regardless of lockout.
    if (!INPUT_PRESENT) begin
      latch_d = ccs_pkg::RST_LATCH;
    end
    // Hysteresis absorbs the switch dropout chatter between thresholds.
    // Sign and magnitude arrive apart; a negative difference clears the flag unless the load is over the limit.
    if (LOAD_OVER_LIMIT) begin
      supp_d = 1'b1;
    end else if (BAT_MINUS_OUT_POS && BAT_MINUS_OUT_MV > ccs_pkg::SUPP_SET_MV) begin
      supp_d = 1'b1;
    end else if (!BAT_MINUS_OUT_POS || BAT_MINUS_OUT_MV < ccs_pkg::SUPP_CLR_MV) begin
      supp_d = 1'b0;
    end
  end

  // Latch drives switches only in lockout with supply present.
  // Without supply the register bit steers the switches, so the latch is bypassed.
  assign en_eff = (uvlo_q && INPUT_PRESENT) ? latch_q
                                            : cfg_q[ccs_pkg::BIT_ENABLE];

  // Read data and status change event; the supplement bit is excluded from events.
  // The previous word resets to zero, so live status at release shows as one event.
  always_comb begin
    rdata_d     = 8'h00;
    prev_stat_d = st.stat_word;
    irq_d       = |((st.stat_word ^ prev_stat_q) & ~(8'h01 << ccs_pkg::BIT_SUPP));
    if (REG_RD) begin
      unique case (REG_ADDR)
        ccs_pkg::ADDR_CHG_CFG:    rdata_d = cfg_q;
        ccs_pkg::ADDR_PIN3_GUARD: rdata_d = gpio_q;
        ccs_pkg::ADDR_CHARGER_STATUS:   rdata_d = st.stat_word;
        default:                  rdata_d = 8'h00;
      endcase
    end
  end

  // Registers of all control state.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q       <= ccs_pkg::RST_CHG_CFG;
      gpio_q      <= ccs_pkg::RST_PIN3_GUARD;
      latch_q     <= ccs_pkg::RST_LATCH;
      uvlo_q      <= 1'b0;
      supp_q      <= 1'b0;
      rdata_q     <= 8'h00;
      prev_stat_q <= 8'h00;
      irq_q       <= 1'b0;
    end else begin
      cfg_q       <= cfg_d;
      gpio_q      <= gpio_d;
      latch_q     <= latch_d;
      uvlo_q      <= uvlo_d;
      supp_q      <= supp_d;
      rdata_q     <= rdata_d;
      prev_stat_q <= prev_stat_d;
      irq_q       <= irq_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------------
  logic       vsel_q, guard_q, susp_q, hold_q, lim_q, sys_q, suppo_q;
  logic       vsel_d, guard_d, susp_d, hold_d, lim_d, sys_d, suppo_d;
  logic [2:0] cur_q;
  logic [2:0] cur_d;

  // Next pin values, each taken from its register field, the effective enable or the supplement flag.
  // The copy costs one cycle of latency but keeps every pin free of decode glitches.
  always_comb begin
    vsel_d  = cfg_q[ccs_pkg::BIT_VSEL];
    guard_d = gpio_q[ccs_pkg::BIT_GUARD];
    susp_d  = cfg_q[ccs_pkg::BIT_SUSPEND];
    hold_d  = ~cfg_q[ccs_pkg::BIT_SUSPEND];
    cur_d   = cfg_q[4:2];
    lim_d   = cfg_q[1];
    sys_d   = en_eff;
    suppo_d = supp_q;
  end

  // Pin registers; reset values follow the power-up register contents.
  always_ff @(posedge REF_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      vsel_q  <= ccs_pkg::RST_CHG_CFG[ccs_pkg::BIT_VSEL];
      guard_q <= ccs_pkg::RST_PIN3_GUARD[ccs_pkg::BIT_GUARD];
      susp_q  <= ccs_pkg::RST_CHG_CFG[ccs_pkg::BIT_SUSPEND];
      hold_q  <= ~ccs_pkg::RST_CHG_CFG[ccs_pkg::BIT_SUSPEND];
      cur_q   <= ccs_pkg::RST_CHG_CFG[4:2];
      lim_q   <= ccs_pkg::RST_CHG_CFG[1];
      sys_q   <= ccs_pkg::RST_CHG_CFG[ccs_pkg::BIT_ENABLE];
      suppo_q <= 1'b0;
    end else begin
      vsel_q  <= vsel_d;
      guard_q <= guard_d;
      susp_q  <= susp_d;
      hold_q  <= hold_d;
      cur_q   <= cur_d;
      lim_q   <= lim_d;
      sys_q   <= sys_d;
      suppo_q <= suppo_d;
    end
  end

  assign CHARGE_VOLTAGE_SELECT    = vsel_q;
  assign CHARGE_VOLTAGE_GUARD_BIT = guard_q;
  assign SUSPEND_CHARGE_CONTROL   = susp_q;
  assign TIMERS_HOLD              = hold_q;
  assign CURRENT_CFG              = cur_q;
  assign INPUT_LIMIT_MAX          = lim_q;
  assign SYSTEM_FROM_INPUT        = sys_q;
  assign SUPPLEMENT_FLAG          = suppo_q;
  assign STATUS_IRQ_EVENT         = irq_q;
  assign REG_RDATA                = rdata_q;
endmodule : ccs_regs

// ### common/ccs_pkg.sv
// Package of register map constants and encodings for the charger control and status registers.
// Behaviour
// - On output undervoltage lockout, capture enable bit into latch, then reset register bit.
// - During lockout with supply present, switch state follows the captured latch.
// - Captured latch returns to high only when input power is removed.
// - Leaving lockout disables the latch; the register bit steers switches again.
// - Supplement flag sets above 60 mV excess, clears below 20 mV.
// - Supplement mode entered when load exceeds input limit or supply capability.
// - Supplement flag never raises an interrupt.
// - Charge state codes: 00 fault/off/suspend, 01 done, 10 fast, 11 precharge.
// - Loop flag is one when dynamic power-path or thermal loop is active.
// - Overvoltage flag is one when either input sees overvoltage.
// - Status contents are valid only while the monitor regulator is in regulation.
// - Clearing suspend control holds both safety timers without resetting them.
package ccs_pkg;
  // ----------------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN3_GUARD = 8'h1C;
  localparam logic [7:0] ADDR_CHG_CFG    = 8'h1A;
  localparam logic [7:0] ADDR_CHARGER_STATUS   = 8'h1B;
  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int BIT_GUARD     = 4;
  localparam int BIT_VSEL      = 7;
  localparam int BIT_SUSPEND   = 6;
  localparam int BIT_ENABLE    = 0;
  localparam int BIT_SUPP      = 7;
  // ----------------------------------------------------------------------------
  // Reset values and write mask
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RST_PIN3_GUARD = 8'h00;
  localparam logic [7:0] RST_CHG_CFG    = 8'hC1;
  localparam logic [7:0] CFG_WR_MASK    = 8'hDF;
  localparam logic       RST_LATCH      = 1'b1;
  // ----------------------------------------------------------------------------
  // Charge state codes
  // ----------------------------------------------------------------------------
  localparam logic [1:0] ST_FAULT = 2'h0;
  localparam logic [1:0] ST_DONE  = 2'h1;
  localparam logic [1:0] ST_FAST  = 2'h2;
  localparam logic [1:0] ST_PRE   = 2'h3;
  // Supplement thresholds in millivolts.
  localparam logic [11:0] SUPP_SET_MV = 12'h03C;
  localparam logic [11:0] SUPP_CLR_MV = 12'h014;
endpackage : ccs_pkg

// ### common/ccs_stat_if.sv
// Interface carrying live status inputs from the top to the status composer.
`timescale 1ns/1ns
interface ccs_stat_if;
  logic        supp_flag;
  logic        usb_sel;
  logic        dynamic_power_path_management_on;
  logic        therm_on;
  logic        ac_pg;
  logic        usb_pg;
  logic [1:0]  chg_state;
  logic        ac_ov;
  logic        usb_ov;
  logic        pm_ok;
  logic [7:0]  stat_word;
  modport src (output supp_flag, usb_sel, dynamic_power_path_management_on, therm_on, ac_pg, usb_pg,
               chg_state, ac_ov, usb_ov, pm_ok, input stat_word);
  modport comp (input supp_flag, usb_sel, dynamic_power_path_management_on, therm_on, ac_pg, usb_pg,
                chg_state, ac_ov, usb_ov, pm_ok, output stat_word);
endinterface : ccs_stat_if

// ### hdl/ccs_stat_comp.sv
// Combinational composer of the charger status word.
`timescale 1ns/1ns
module ccs_stat_comp (
  // Status bundle
  ccs_stat_if.comp st
);
  // Status is forced to zero when the monitor regulator is out of regulation, since it is meaningless then.
  always_comb begin
    if (st.pm_ok) begin
      st.stat_word = {st.supp_flag, st.usb_sel,
                      st.dynamic_power_path_management_on | st.therm_on,
                      st.ac_pg, st.usb_pg,
                      st.chg_state,
                      st.ac_ov | st.usb_ov};
    end else begin
      st.stat_word = 8'h00;
    end
  end
endmodule : ccs_stat_comp

// ### sim/ccs_host.sv
// Host-side model that drives the register port of the charger bank.
`timescale 1ns/1ns
module ccs_host (
  // Register port
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  // Bus idles with no strobe from time zero.
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One write; data turns to garbage once released so no stale value is trusted.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d;
  endtask : wr_reg

  // One read; the answer stands right after the taking edge and is sampled on the next falling edge.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg

  // Present flags mean nothing once the monitor regulator drops out.
  function automatic logic [1:0] pg_view(input logic [7:0] s, input logic pm);
    return pm ? s[4:3] : 2'b00;
  endfunction : pg_view
endmodule : ccs_host

// ### sim/ccs_regs_sva.sv
// Assertion checker for the charger register bank ports.
`timescale 1ns/1ns
module ccs_regs_sva (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RESETN,
  // Register port
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  // Analog events and measurements
  input wire logic        OUT_UVLO,
  input wire logic        INPUT_PRESENT,
  input wire logic [11:0] BAT_MINUS_OUT_MV,
  input wire logic        BAT_MINUS_OUT_POS,
  input wire logic        LOAD_OVER_LIMIT,
  // Live status inputs
  input wire logic        USB_SELECTED,
  input wire logic        DYNAMIC_POWER_PATH_MANAGEMENT_ACTIVE,
  input wire logic        THERMAL_ACTIVE,
  input wire logic        WALL_INPUT_PRESENT,
  input wire logic        USB_INPUT_PRESENT,
  input wire logic [1:0]  CHARGE_STATE,
  input wire logic        AC_OVERVOLTAGE,
  input wire logic        USB_OVERVOLTAGE,
  input wire logic        PM_REG_OK,
  // Watched controls
  input wire logic        CHARGE_VOLTAGE_GUARD_BIT,
  input wire logic        SUSPEND_CHARGE_CONTROL,
  input wire logic        TIMERS_HOLD,
  input wire logic        SYSTEM_FROM_INPUT,
  input wire logic        SUPPLEMENT_FLAG,
  input wire logic        STATUS_IRQ_EVENT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  logic [9:0] live;
  logic [9:0] live_q;
  logic [2:0] quiet_q;
  logic [2:0] quiet_d;
  logic       rd_s;
  assign live = {USB_SELECTED, DYNAMIC_POWER_PATH_MANAGEMENT_ACTIVE, THERMAL_ACTIVE, WALL_INPUT_PRESENT,
                 USB_INPUT_PRESENT, CHARGE_STATE, AC_OVERVOLTAGE, USB_OVERVOLTAGE, PM_REG_OK};
  assign rd_s = REG_RD && REG_ADDR == ccs_pkg::ADDR_CHARGER_STATUS;
  // Quiet spell of every status input but the supplement flag, saturating at 7.
  always_comb begin
    quiet_d = (live != live_q) ? 3'h0 : ((quiet_q == 3'h7) ? 3'h7 : quiet_q + 3'h1);
  end
  // Registers of the quiet counter.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      live_q  <= 10'h000;
      quiet_q <= 3'h0;
    end else begin
      live_q  <= live;
      quiet_q <= quiet_d;
    end
  end
  property p_off; rd_s && !PM_REG_OK |=> REG_RDATA == 8'h00; endproperty
  a_off: assert property (p_off) else $error("status not blank");
  property p_state; rd_s && PM_REG_OK |=> REG_RDATA[2:1] == $past(CHARGE_STATE); endproperty
  a_state: assert property (p_state) else $error("charge state code");
  property p_loop; rd_s && PM_REG_OK |=> REG_RDATA[5] == $past(DYNAMIC_POWER_PATH_MANAGEMENT_ACTIVE || THERMAL_ACTIVE); endproperty
  a_loop: assert property (p_loop) else $error("loop flag");
  property p_ov; rd_s && PM_REG_OK |=> REG_RDATA[0] == $past(AC_OVERVOLTAGE || USB_OVERVOLTAGE); endproperty
  a_ov: assert property (p_ov) else $error("overvoltage flag");
  property p_irq; quiet_q == 3'h7 |-> !STATUS_IRQ_EVENT; endproperty
  a_irq: assert property (p_irq) else $error("event from supplement");
  property p_set; (BAT_MINUS_OUT_POS && BAT_MINUS_OUT_MV > 12'h03C) [*6] |-> SUPPLEMENT_FLAG; endproperty
  a_set: assert property (p_set) else $error("supplement not set");
  property p_clr; (!LOAD_OVER_LIMIT && (!BAT_MINUS_OUT_POS || BAT_MINUS_OUT_MV < 12'h014)) [*6]
    |-> !SUPPLEMENT_FLAG; endproperty
  a_clr: assert property (p_clr) else $error("supplement not cleared");
  property p_load; LOAD_OVER_LIMIT [*6] |-> SUPPLEMENT_FLAG; endproperty
  a_load: assert property (p_load) else $error("overload without supplement");
  property p_uvlo; $rose(OUT_UVLO) && INPUT_PRESENT && $stable(SYSTEM_FROM_INPUT) ##1
    (OUT_UVLO && INPUT_PRESENT) [*3] |-> SYSTEM_FROM_INPUT == $past(SYSTEM_FROM_INPUT, 3); endproperty
  a_uvlo: assert property (p_uvlo) else $error("lockout lost enable");
  property p_guard; REG_WR && REG_ADDR == ccs_pkg::ADDR_PIN3_GUARD
    |-> ##2 CHARGE_VOLTAGE_GUARD_BIT == $past(REG_WDATA[4], 2); endproperty
  a_guard: assert property (p_guard) else $error("guard bit");
  property p_hold; TIMERS_HOLD != SUSPEND_CHARGE_CONTROL; endproperty
  a_hold: assert property (p_hold) else $error("timer hold");
  c_uvlo: cover property ($rose(OUT_UVLO) ##3 OUT_UVLO);
  c_supp: cover property ($rose(SUPPLEMENT_FLAG));
  c_stat: cover property (rd_s && PM_REG_OK);
endmodule : ccs_regs_sva
bind ccs_regs ccs_regs_sva u_sva (.*);

// ### sim/test_ccs_regs.sv
// Self-checking bench for the charger register bank.
`timescale 1ns/1ns
module test_ccs_regs;
  // Design ports, named as on the block
  logic        REF_CLK, RESETN, REG_WR, REG_RD, OUT_UVLO, INPUT_PRESENT, BAT_MINUS_OUT_POS;
  logic        LOAD_OVER_LIMIT, USB_SELECTED, DYNAMIC_POWER_PATH_MANAGEMENT_ACTIVE, THERMAL_ACTIVE, WALL_INPUT_PRESENT;
  logic        USB_INPUT_PRESENT, AC_OVERVOLTAGE, USB_OVERVOLTAGE, PM_REG_OK, TIMERS_HOLD;
  logic        CHARGE_VOLTAGE_SELECT, CHARGE_VOLTAGE_GUARD_BIT, SUSPEND_CHARGE_CONTROL;
  logic        INPUT_LIMIT_MAX, SYSTEM_FROM_INPUT, SUPPLEMENT_FLAG, STATUS_IRQ_EVENT;
  logic [1:0]  CHARGE_STATE;
  logic [2:0]  CURRENT_CFG;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, rd_v;
  logic [11:0] BAT_MINUS_OUT_MV;
  int          num_errors = 0;
  int          num_checks = 0;
  ccs_regs dut (.*);
  ccs_host host (.clk(REF_CLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD),
                 .rdata(REG_RDATA));
  // Free-running clock, 4 ns period.
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge REF_CLK);
  endtask : cyc
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // Reset values, the unused bit, field outputs and an unmapped read.
  task automatic t_regs();
    host.rd_reg(8'h1A, rd_v);
    chk("cfg reset", rd_v, 8'hC1);
    host.rd_reg(8'h1C, rd_v);
    chk("guard reset", rd_v, 8'h00);
    host.wr_reg(8'h1A, 8'hFF);
    host.rd_reg(8'h1A, rd_v);
    chk("cfg bit5", rd_v, 8'hDF);
    chk("current", {3'h0, CURRENT_CFG, INPUT_LIMIT_MAX, CHARGE_VOLTAGE_SELECT}, 8'h1F);
    host.rd_reg(8'h00, rd_v);
    chk("unmapped", rd_v, 8'h00);
  endtask : t_regs
  // Guard bit and suspend with timer hold, written back to back.
  task automatic t_ctrl();
    host.wr_reg(8'h1C, 8'h10);
    host.wr_reg(8'h1A, 8'h81);
    cyc(1);
    chk("guard set", {7'h00, CHARGE_VOLTAGE_GUARD_BIT}, 8'h01);
    chk("suspend", {6'h00, SUSPEND_CHARGE_CONTROL, TIMERS_HOLD}, 8'h01);
    host.wr_reg(8'h1C, 8'hEF);
    host.wr_reg(8'h1A, 8'hC1);
    cyc(1);
    chk("guard clear", {7'h00, CHARGE_VOLTAGE_GUARD_BIT}, 8'h00);
    chk("resume", {6'h00, SUSPEND_CHARGE_CONTROL, TIMERS_HOLD}, 8'h02);
  endtask : t_ctrl
  // Every charge state code with mixed live flags, a refused write, a dead monitor.
  task automatic t_status();
    logic [7:0] e;
    for (int i = 0; i < 32; i++) begin
      {USB_SELECTED, THERMAL_ACTIVE, DYNAMIC_POWER_PATH_MANAGEMENT_ACTIVE, CHARGE_STATE} = i[4:0];
      WALL_INPUT_PRESENT = i[0];
      USB_INPUT_PRESENT = i[1] ^ i[4];
      AC_OVERVOLTAGE = i[2] & i[0];
      USB_OVERVOLTAGE = i[3] & i[1];
      e = {1'b0, i[4], i[3] | i[2], i[0], i[1] ^ i[4], i[1:0], (i[2] & i[0]) | (i[3] & i[1])};
      host.rd_reg(8'h1B, rd_v);
      chk("status", rd_v, e);
      chk("present view", {6'h00, host.pg_view(rd_v, PM_REG_OK)},
          {6'h00, i[0], i[1] ^ i[4]});
    end
    host.wr_reg(8'h1B, 8'h00);
    host.rd_reg(8'h1B, rd_v);
    chk("status write", rd_v, e);
    PM_REG_OK = 1'b0;
    host.rd_reg(8'h1B, rd_v);
    chk("status off", rd_v, 8'h00);
    PM_REG_OK = 1'b1;
    // Status turning valid again is a change, so one event pulse follows.
    cyc(1);
    chk("status event", {7'h00, STATUS_IRQ_EVENT}, 8'h01);
    cyc(1);
    chk("event ends", {7'h00, STATUS_IRQ_EVENT}, 8'h00);
  endtask : t_status
  // Hysteresis walk: set, hold, clear, hold, negative, overload, clear.
  task automatic t_supp();
    logic [14:0] tbl [7] = '{15'h5046, 15'h5028, 15'h100A, 15'h1028, 15'h0064, 15'h6000, 15'h0000};
    foreach (tbl[k]) begin
      {LOAD_OVER_LIMIT, BAT_MINUS_OUT_POS, BAT_MINUS_OUT_MV} = tbl[k][13:0];
      cyc(2);
      chk("supplement event", {7'h00, STATUS_IRQ_EVENT}, 8'h00);
      cyc(2);
      host.rd_reg(8'h1B, rd_v);
      chk("supplement", {6'h00, SUPPLEMENT_FLAG, rd_v[7]}, {6'h00, {2{tbl[k][14]}}});
    end
  endtask : t_supp
  // Lockout capture, release, and latch return on input removal.
  task automatic t_uvlo();
    host.wr_reg(8'h1A, 8'hC0);
    cyc(2);
    OUT_UVLO = 1'b1;
    cyc(3);
    chk("sys latched", {7'h00, SYSTEM_FROM_INPUT}, 8'h00);
    host.rd_reg(8'h1A, rd_v);
    chk("cfg after lockout", rd_v, 8'hC1);
    OUT_UVLO = 1'b0;
    cyc(3);
    chk("sys from cfg", {7'h00, SYSTEM_FROM_INPUT}, 8'h01);
    host.wr_reg(8'h1A, 8'hC0);
    cyc(1);
    OUT_UVLO = 1'b1;
    cyc(2);
    INPUT_PRESENT = 1'b0;
    cyc(2);
    INPUT_PRESENT = 1'b1;
    cyc(3);
    chk("latch restored", {7'h00, SYSTEM_FROM_INPUT}, 8'h01);
    OUT_UVLO = 1'b0;
    cyc(3);
  endtask : t_uvlo
  // Main sequence: everything quiet, reset for three cycles, then the scenarios.
  initial begin
    {RESETN, OUT_UVLO, BAT_MINUS_OUT_POS, LOAD_OVER_LIMIT, BAT_MINUS_OUT_MV} = '0;
    {USB_SELECTED, DYNAMIC_POWER_PATH_MANAGEMENT_ACTIVE, THERMAL_ACTIVE, WALL_INPUT_PRESENT, USB_INPUT_PRESENT} = '0;
    {CHARGE_STATE, AC_OVERVOLTAGE, USB_OVERVOLTAGE} = '0;
    {INPUT_PRESENT, PM_REG_OK} = 2'b11;
    cyc(3);
    RESETN = 1'b1;
    cyc(3);
    t_regs();
    t_ctrl();
    t_status();
    t_supp();
    t_uvlo();
    tally_and_finish();
  end
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #20000;
    num_errors++;
    tally_and_finish();
  end
endmodule : test_ccs_regs
